// ===== tcs_top.sv
// Telemetry calibration and scaling: calibration registers and scaled words.
//
// Functional notes
// R01: Current offset register: six writable bits 5:0, upper bits read zero.
// R02: Input gain register: ten writable unsigned bits 9:0, upper bits zero.
// R03: Raw input sample is the ten-bit converter result of the input sense.
// R04: Input telemetry equals raw input times 205 over input gain.
// R05: Output gain register: ten writable unsigned bits 9:0, upper bits zero.
// R06: Raw output sample is the ten-bit converter result of output sense.
// R07: Output telemetry equals raw output times 205 over four times gain.
// R08: Overvoltage limit register: nine writable bits 8:0, 0.25 V per count.
// R09: Limit is compared against bits 9:1 of the input telemetry word.
// R10: Host programs input gain as divider ratio times two to fourteen.
// R11: Host programs output gain as divider ratio times two to eleven.
// R12: Fault when compared bits exceed limit; quotients truncate toward zero.
`timescale 1ns/1ps
module tcs_top (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [tcs_pkg::TCS_CMD_W-1:0] cmd_i,
	input wire logic [tcs_pkg::TCS_DATA_W-1:0] wr_data_i,
	output logic [tcs_pkg::TCS_DATA_W-1:0] rd_data_o,
	output logic rd_ack_o,
	input wire logic sample_valid_i,
	input wire tcs_pkg::tcs_sample_t sample_i,
	output logic [tcs_pkg::TCS_VIN_W-1:0] vin_telemetry_o,
	output logic [tcs_pkg::TCS_VOUT_W-1:0] vout_telemetry_o,
	output logic [tcs_pkg::TCS_OFS_MSB:0] current_cal_offset_o,
	output logic ov_fault_o,
	output logic busy_o
);
	import tcs_pkg::*;

	logic [TCS_OFS_MSB:0] current_cal_offset_r;
	logic [TCS_GAIN_MSB:0] input_voltage_gain_r;
	logic [TCS_GAIN_MSB:0] output_voltage_gain_r;
	logic [TCS_LIM_MSB:0] input_overvoltage_limit_r;
	logic [TCS_DATA_W-1:0] rd_data_r;
	logic [TCS_DATA_W-1:0] rd_data_nxt;
	logic rd_ack_r;
	tcs_sample_t sample_r;
	logic pend_r;
	tcs_state_t state_r;
	logic start_r;
	logic [TCS_DVD_W-1:0] dividend_r;
	logic [TCS_DVS_W-1:0] divisor_r;
	logic [TCS_DVD_W-1:0] quotient;
	logic div_done;
	logic [TCS_VIN_W-1:0] vin_r;
	logic [TCS_VOUT_W-1:0] vout_r;
	logic fault_r;
	logic busy_r;

	////////////////////////////////////////////////////////////////////////
	// Register writes keep only the documented field widths.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			current_cal_offset_r <= TCS_OFS_RST;
			input_voltage_gain_r <= TCS_VIN_GAIN_RST;
			output_voltage_gain_r <= TCS_VOUT_GAIN_RST;
			input_overvoltage_limit_r <= TCS_LIM_RST;
		end else if (wr_en_i) begin
			case (cmd_i)
				// R01: offset field write
				TCS_CMD_CUR_OFS: begin
					current_cal_offset_r <= wr_data_i[TCS_OFS_MSB:0];
				end
				// R02: input gain write
				TCS_CMD_VIN_GAIN: begin
					input_voltage_gain_r <= wr_data_i[TCS_GAIN_MSB:0];
				end
				// R05: output gain write
				TCS_CMD_VOUT_GAIN: begin
					output_voltage_gain_r <= wr_data_i[TCS_GAIN_MSB:0];
				end
				// R08: limit field write
				TCS_CMD_VIN_OV_LIM: begin
					input_overvoltage_limit_r <= wr_data_i[TCS_LIM_MSB:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Reserved upper bits and unknown commands read as zero.
	always_comb begin
		rd_data_nxt = '0;
		case (cmd_i)
			// R01: reserved bits zero
			TCS_CMD_CUR_OFS: begin
				rd_data_nxt[TCS_OFS_MSB:0] = current_cal_offset_r;
			end
			// R02: reserved bits zero
			TCS_CMD_VIN_GAIN: begin
				rd_data_nxt[TCS_GAIN_MSB:0] = input_voltage_gain_r;
			end
			// R05: reserved bits zero
			TCS_CMD_VOUT_GAIN: begin
				rd_data_nxt[TCS_GAIN_MSB:0] = output_voltage_gain_r;
			end
			// R08: reserved bits zero
			TCS_CMD_VIN_OV_LIM: begin
				rd_data_nxt[TCS_LIM_MSB:0] = input_overvoltage_limit_r;
			end
			default: begin
				rd_data_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_data_r <= '0;
			rd_ack_r <= 1'b0;
		end else begin
			rd_ack_r <= rd_en_i;
			if (rd_en_i) begin
				rd_data_r <= rd_data_nxt;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The converter shares the core clock, so samples need no synchroniser.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sample_r <= '0;
		end else if (sample_valid_i) begin
			// R03: raw input capture
			// R06: raw output capture
			sample_r <= sample_i;
		end
	end

	// A new sample arriving as the old one is taken is kept pending.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pend_r <= 1'b0;
		end else if (sample_valid_i) begin
			pend_r <= 1'b1;
		end else if (state_r == TCS_S_IDLE) begin
			pend_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// One shared divider: input first, then output, to save area.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r <= TCS_S_IDLE;
			start_r <= 1'b0;
			dividend_r <= '0;
			divisor_r <= '0;
			vin_r <= '0;
			vout_r <= '0;
		end else begin
			start_r <= 1'b0;
			case (state_r)
				TCS_S_IDLE: begin
					if (pend_r) begin
						// R04: input scaling operands
						dividend_r <= TCS_DVD_W'(sample_r.vin) *
							TCS_DVD_W'(TCS_SCALE_MUL);
						divisor_r <= TCS_DVS_W'(input_voltage_gain_r);
						start_r <= 1'b1;
						state_r <= TCS_S_VIN;
					end
				end
				TCS_S_VIN: begin
					if (div_done) begin
						// R04: saturate input word
						vin_r <= (|quotient[TCS_DVD_W-1:TCS_VIN_W]) ?
							'1 : quotient[TCS_VIN_W-1:0];
						// R07: output scaling operands
						dividend_r <= TCS_DVD_W'(sample_r.vout) *
							TCS_DVD_W'(TCS_SCALE_MUL);
						divisor_r <= {output_voltage_gain_r,
							TCS_VOUT_DIV_PAD};
						start_r <= 1'b1;
						state_r <= TCS_S_VOUT;
					end
				end
				TCS_S_VOUT: begin
					if (div_done) begin
						// R07: saturate output word
						vout_r <= (|quotient[TCS_DVD_W-1:TCS_VOUT_W]) ?
							'1 : quotient[TCS_VOUT_W-1:0];
						state_r <= TCS_S_IDLE;
					end
				end
				default: begin
					state_r <= TCS_S_IDLE;
				end
			endcase
		end
	end

	tcs_div #(
		.DVD_W(TCS_DVD_W),
		.DVS_W(TCS_DVS_W)
	) u_div (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.start_i(start_r),
		.dividend_i(dividend_r),
		.divisor_i(divisor_r),
		.quotient_o(quotient),
		.done_o(div_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Compared every cycle, so a limit write takes effect without a sample.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fault_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			// R09: bits 9:1 compare
			// R12: strictly above limit
			fault_r <= (vin_r[TCS_VIN_W-1:1] > input_overvoltage_limit_r);
			busy_r <= (state_r != TCS_S_IDLE) || pend_r;
		end
	end

	assign rd_data_o = rd_data_r;
	assign rd_ack_o = rd_ack_r;
	assign vin_telemetry_o = vin_r;
	assign vout_telemetry_o = vout_r;
	assign current_cal_offset_o = current_cal_offset_r;
	assign ov_fault_o = fault_r;
	assign busy_o = busy_r;

endmodule

// ===== tcs_pkg.sv
// Package of constants and types for telemetry calibration and scaling.
package tcs_pkg;

	localparam int unsigned TCS_RAW_W = 10;
	localparam int unsigned TCS_DATA_W = 16;
	localparam int unsigned TCS_CMD_W = 8;
	localparam int unsigned TCS_DVD_W = 18;
	localparam int unsigned TCS_DVS_W = 12;
	localparam int unsigned TCS_VIN_W = 10;
	localparam int unsigned TCS_VOUT_W = 9;

	////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] TCS_CMD_CUR_OFS = 8'h39;
	localparam logic [7:0] TCS_CMD_VIN_GAIN = 8'h3a;
	localparam logic [7:0] TCS_CMD_VOUT_GAIN = 8'h3b;
	localparam logic [7:0] TCS_CMD_VIN_OV_LIM = 8'h40;

	localparam int unsigned TCS_OFS_MSB = 5;
	localparam int unsigned TCS_GAIN_MSB = 9;
	localparam int unsigned TCS_LIM_MSB = 8;

	localparam logic [5:0] TCS_OFS_RST = 6'h00;
	localparam logic [9:0] TCS_VIN_GAIN_RST = 10'h155;
	localparam logic [9:0] TCS_VOUT_GAIN_RST = 10'h155;
	localparam logic [8:0] TCS_LIM_RST = 9'h1ff;

	localparam logic [7:0] TCS_SCALE_MUL = 8'hcd;
	localparam logic [1:0] TCS_VOUT_DIV_PAD = 2'h0;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [TCS_RAW_W-1:0] vin;
		logic [TCS_RAW_W-1:0] vout;
	} tcs_sample_t;

	typedef enum logic [2:0] {
		TCS_S_IDLE = 3'b001,
		TCS_S_VIN = 3'b010,
		TCS_S_VOUT = 3'b100
	} tcs_state_t;

endpackage

// ===== tcs_div.sv
// Sequential restoring unsigned divider used for telemetry scaling.
`timescale 1ns/1ps
module tcs_div #(
	parameter int unsigned DVD_W = 18,
	parameter int unsigned DVS_W = 12
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic start_i,
	input wire logic [DVD_W-1:0] dividend_i,
	input wire logic [DVS_W-1:0] divisor_i,
	output logic [DVD_W-1:0] quotient_o,
	output logic done_o
);

	localparam int unsigned CNT_W = $clog2(DVD_W + 1);

	logic [DVD_W-1:0] quo_r;
	logic [DVS_W:0] rem_r;
	logic [DVS_W-1:0] dvs_r;
	logic [CNT_W-1:0] cnt_r;
	logic done_r;
	logic [DVS_W:0] shifted;
	logic take;

	assign shifted = {rem_r[DVS_W-1:0], quo_r[DVD_W-1]};
	assign take = (shifted >= {1'b0, dvs_r});

	// A zero divisor yields an all-ones quotient, which saturates downstream.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			quo_r <= '0;
			rem_r <= '0;
			dvs_r <= '0;
			cnt_r <= '0;
		end else if (start_i) begin
			quo_r <= dividend_i;
			rem_r <= '0;
			dvs_r <= divisor_i;
			cnt_r <= CNT_W'(DVD_W);
		end else if (cnt_r != '0) begin
			// R12: truncating quotient
			if (take) begin
				rem_r <= shifted - {1'b0, dvs_r};
				quo_r <= {quo_r[DVD_W-2:0], 1'b1};
			end else begin
				rem_r <= shifted;
				quo_r <= {quo_r[DVD_W-2:0], 1'b0};
			end
			cnt_r <= cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			done_r <= 1'b0;
		end else begin
			done_r <= (!start_i) && (cnt_r == CNT_W'(1));
		end
	end

	assign quotient_o = quo_r;
	assign done_o = done_r;

endmodule

// ===== tcs_checker.sv
// Checker of register and telemetry relations at the block ports.
`timescale 1ns/1ps
module tcs_checker (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [tcs_pkg::TCS_CMD_W-1:0] cmd_i,
	input wire logic [tcs_pkg::TCS_DATA_W-1:0] wr_data_i,
	input wire logic [tcs_pkg::TCS_DATA_W-1:0] rd_data_o,
	input wire logic rd_ack_o,
	input wire logic sample_valid_i,
	input wire logic [tcs_pkg::TCS_VIN_W-1:0] vin_telemetry_o,
	input wire logic [tcs_pkg::TCS_VOUT_W-1:0] vout_telemetry_o,
	input wire logic ov_fault_o,
	input wire logic busy_o
);
	import tcs_pkg::*;
	logic [8:0] lim_r;
	// The limit is mirrored here because the block does not expose it.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lim_r <= TCS_LIM_RST;
		end else if (wr_en_i && cmd_i == TCS_CMD_VIN_OV_LIM) begin
			lim_r <= wr_data_i[TCS_LIM_MSB:0];
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	a_read_ack: assert property (rd_en_i |=> rd_ack_o)
		else $error("read not answered");
	a_ofs_rsvd: assert property (rd_ack_o && $past(cmd_i) == TCS_CMD_CUR_OFS
		|-> rd_data_o[15:6] == 10'h000)
		else $error("offset reserved bits set");
	a_gain_rsvd: assert property (rd_ack_o && ($past(cmd_i) ==
		TCS_CMD_VIN_GAIN || $past(cmd_i) == TCS_CMD_VOUT_GAIN)
		|-> rd_data_o[15:10] == 6'h00)
		else $error("gain reserved bits set");
	a_lim_rsvd: assert property (rd_ack_o && $past(cmd_i) ==
		TCS_CMD_VIN_OV_LIM |-> rd_data_o[15:9] == 7'h00)
		else $error("limit reserved bits set");
	a_lim_read: assert property (rd_ack_o && $past(cmd_i) ==
		TCS_CMD_VIN_OV_LIM |-> rd_data_o[8:0] == $past(lim_r))
		else $error("limit readback wrong");
	a_fault_rel: assert property ($stable(vin_telemetry_o) && $stable(lim_r)
		|-> ov_fault_o == (vin_telemetry_o[9:1] > lim_r))
		else $error("fault does not match limit");
	a_busy_start: assert property (sample_valid_i |-> ##[1:3] busy_o)
		else $error("sample did not start work");
	a_out_steady: assert property (!busy_o && !$past(busy_o)
		|-> $stable({vin_telemetry_o, vout_telemetry_o}))
		else $error("telemetry moved while idle");
	cover property (rd_ack_o);
	cover property ($fell(busy_o));
	cover property ($rose(ov_fault_o));
endmodule
bind tcs_top tcs_checker u_tcs_checker (.clk_sys_i, .rst_b_i, .wr_en_i,
	.rd_en_i, .cmd_i, .wr_data_i, .rd_data_o, .rd_ack_o, .sample_valid_i,
	.vin_telemetry_o, .vout_telemetry_o, .ov_fault_o, .busy_o);

// ===== tcs_conv_model.sv
// Behavioural converter that presents raw sample pairs to the block.
`timescale 1ns/1ps
module tcs_conv_model (
	input wire logic clk_sys_i,
	input wire logic go_i,
	input wire logic [9:0] vin_i,
	input wire logic [9:0] vout_i,
	output logic sample_valid_o = 1'b0,
	output tcs_pkg::tcs_sample_t sample_o = '0
);
	import tcs_pkg::*;
	always @(posedge clk_sys_i) begin
		sample_valid_o <= go_i;
		// Lines toggle between results so a stale sample cannot pass.
		if (go_i) begin
			sample_o <= '{vin: vin_i, vout: vout_i};
		end else begin
			sample_o <= ~sample_o;
		end
	end
endmodule

// ===== tb.sv
// Self-checking bench for telemetry calibration and scaling.
`timescale 1ns/1ps
module tb;
	import tcs_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic wr_en_i = 1'b0;
	logic rd_en_i = 1'b0;
	logic go = 1'b0;
	logic [7:0] cmd_i = 8'h00;
	logic [15:0] wr_data_i = 16'h0000;
	logic [15:0] rd_data_o;
	logic rd_ack_o, sample_valid_i, ov_fault_o, busy_o;
	logic [9:0] vin_telemetry_o;
	logic [9:0] rv = 10'h000;
	logic [9:0] ro = 10'h000;
	logic [8:0] vout_telemetry_o;
	logic [5:0] current_cal_offset_o;
	tcs_sample_t sample_i;
	logic [7:0] cmds [5] = '{8'h39, 8'h3a, 8'h3b, 8'h40, 8'h41};
	logic [15:0] rst_v [5] = '{16'h0, 16'h155, 16'h155, 16'h1ff, 16'h0};
	logic [15:0] wr_v [5] = '{16'h3f, 16'h3ff, 16'h3ff, 16'h1ff, 16'h0};
	int n_fail = 0;
	int n_compared = 0;
	int cyc = 0;
	always #20 clk_sys_i = ~clk_sys_i;
	tcs_top u_tcs_top (.clk_sys_i, .rst_b_i, .wr_en_i, .rd_en_i, .cmd_i,
		.wr_data_i, .rd_data_o, .rd_ack_o, .sample_valid_i, .sample_i,
		.vin_telemetry_o, .vout_telemetry_o, .current_cal_offset_o,
		.ov_fault_o, .busy_o);
	tcs_conv_model u_tcs_conv_model (.clk_sys_i, .go_i(go), .vin_i(rv),
		.vout_i(ro), .sample_valid_o(sample_valid_i), .sample_o(sample_i));
	////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] ex);
		n_compared++;
		if (seen !== ex) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	task wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge clk_sys_i);
		#1;
		wr_en_i = 1'b1;
		cmd_i = c;
		wr_data_i = d;
		@(posedge clk_sys_i);
		#1;
		wr_en_i = 1'b0;
	endtask
	task rd(input logic [7:0] c, output logic [15:0] d);
		@(posedge clk_sys_i);
		#1;
		rd_en_i = 1'b1;
		cmd_i = c;
		@(posedge clk_sys_i);
		#1;
		rd_en_i = 1'b0;
		chk("read answer", 16'(rd_ack_o), 16'h1);
		d = rd_data_o;
	endtask
	task send(input logic [9:0] a, input logic [9:0] b);
		@(posedge clk_sys_i);
		#1;
		rv = a;
		ro = b;
		go = 1'b1;
		@(posedge clk_sys_i);
		#1;
		go = 1'b0;
		repeat (4) @(posedge clk_sys_i);
		#1;
		chk("busy", 16'(busy_o), 16'h1);
		for (int i = 0; i < 80 && busy_o !== 1'b0; i++) begin
			@(posedge clk_sys_i);
			#1;
		end
		chk("idle", 16'(busy_o), 16'h0);
	endtask
	task t_regs;
		logic [15:0] d;
		for (int i = 0; i < 5; i++) begin
			rd(cmds[i], d);
			chk("reset value", d, rst_v[i]);
			wr(cmds[i], 16'hffff);
			rd(cmds[i], d);
			chk("written value", d, wr_v[i]);
		end
		chk("offset out", 16'(current_cal_offset_o), 16'h3f);
		$display("register test done");
	endtask
	task t_conv;
		// gains from ratios 1/32 and 1/4.
		wr(TCS_CMD_VIN_GAIN, 16'h0200);
		wr(TCS_CMD_VOUT_GAIN, 16'h0200);
		send(10'h001, 10'h3ff);
		chk("vin small", 16'(vin_telemetry_o), 16'(205 / 512));
		chk("vout full", 16'(vout_telemetry_o), 16'(1023 * 205 / 2048));
		send(10'h3ff, 10'h2aa);
		chk("vin full", 16'(vin_telemetry_o), 16'(1023 * 205 / 512));
		chk("vout mid", 16'(vout_telemetry_o), 16'(682 * 205 / 2048));
		$display("scaling test done");
	endtask
	task t_fault;
		wr(TCS_CMD_VIN_OV_LIM, 16'd203);
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk("fault above", 16'(ov_fault_o), 16'h1);
		wr(TCS_CMD_VIN_OV_LIM, 16'd204);
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk("fault at limit", 16'(ov_fault_o), 16'h0);
		$display("fault test done");
	endtask
	task t_sat;
		logic [15:0] d;
		// A zero gain must drive both words to their all-ones ceiling.
		wr(TCS_CMD_VIN_GAIN, 16'h0000);
		wr(TCS_CMD_VOUT_GAIN, 16'h0000);
		send(10'h155, 10'h155);
		chk("vin saturated", 16'(vin_telemetry_o), 16'h03ff);
		chk("vout saturated", 16'(vout_telemetry_o), 16'h01ff);
		chk("fault saturated", 16'(ov_fault_o), 16'h1);
		rst_b_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1;
		rst_b_i = 1'b1;
		chk("vin reset", 16'(vin_telemetry_o), 16'h0000);
		chk("vout reset", 16'(vout_telemetry_o), 16'h0000);
		chk("fault reset", 16'(ov_fault_o), 16'h0000);
		chk("busy reset", 16'(busy_o), 16'h0000);
		chk("offset reset", 16'(current_cal_offset_o), 16'h0000);
		rd(TCS_CMD_VIN_GAIN, d);
		chk("gain reset", d, 16'(TCS_VIN_GAIN_RST));
		rd(TCS_CMD_VIN_OV_LIM, d);
		chk("limit reset", d, 16'(TCS_LIM_RST));
		$display("saturation and reset test done");
	endtask
	task test_done;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk_sys_i);
		#1;
		rst_b_i = 1'b1;
		t_regs;
		t_conv;
		t_fault;
		t_sat;
		test_done;
	end
	// The ceiling is far above the few hundred cycles the tests need.
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			test_done;
		end
	end
endmodule
